// ---- pwr_defines.svh ----
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH

// register offsets on the host register port
`define PWR_OFS_PMEC        8'hD4
`define PWR_OFS_TIMING      8'hD6
`define PWR_OFS_PHYRST      8'hD8
`define PWR_OFS_BCTRL       8'hE4
`define PWR_OFS_BSTAT       8'hE6
`define PWR_OFS_IDLO        8'hE8
`define PWR_OFS_IDHI        8'hEA
`define PWR_OFS_ADV         8'hEC
`define PWR_OFS_LPA         8'hEE
`define PWR_OFS_PCTRL       8'hF6
`define PWR_OFS_PSTAT       8'hF8

// power event control field positions
`define PWR_PMEC_DLY        14
`define PWR_PMEC_POL        12
`define PWR_PMEC_EN_HI      11
`define PWR_PMEC_EN_LO      8
`define PWR_PMEC_AUTO       7
`define PWR_PMEC_W2N        6
`define PWR_PMEC_EVT_HI     5
`define PWR_PMEC_EVT_LO     2

// reset values
`define PWR_RST_WAKE_TIME   8'h08
`define PWR_RST_SLEEP_TIME  8'h0C
`define PWR_RST_ADV         5'h1F
`define PWR_BSTAT_FIXED     16'h3050
`define PWR_ADV_SELECTOR    5'h01

// timing: clock rate and time units
`define PWR_CLK_KHZ         100000
`define PWR_MS_CYC          (`PWR_CLK_KHZ / 1000 * 1000 / 1000 * 1)
`define PWR_WAKE_UNIT_MS    16
`define PWR_SLEEP_UNIT_MS   1000
`define PWR_CYC_PER_MS      (`PWR_CLK_KHZ)

`endif

// ---- pwr_line_model.sv ----
`timescale 1ns/100ps

module pwr_line_model
  import pwr_pkg::*;
(
  // clock
  input  wire logic       clk,
  // bench requests
  input  wire logic       energy_req,
  input  wire logic       link_req,
  input  wire logic [4:0] abil_req,
  input  wire logic       frame_tgl,
  input  wire logic       remote_tgl,
  input  wire logic       ready_req,
  // line side levels and pulses
  output logic            energy_detect = 1'b1,
  output logic            link_up = 1'b0,
  output logic            an_done,
  output logic            op_speed_100,
  output logic            op_full_duplex,
  output logic            mdi_status,
  output logic [4:0]      partner_abil = 5'h00,
  output logic            wake_frame_evt = 1'b0,
  output logic            remote_wake_evt = 1'b0,
  output logic            clocks_ready = 1'b1
);
  logic frame_seen = 1'b0;
  logic remote_seen = 1'b0;

  // autoneg completes with the link, at 100 full
  assign an_done        = link_up;
  assign op_speed_100   = link_up;
  assign op_full_duplex = link_up;
  assign mdi_status     = 1'b1;

  // levels off the falling edge; a toggle request gives one pulse
  always @(negedge clk) begin
    energy_detect   <= energy_req;
    link_up         <= link_req;
    partner_abil    <= link_req ? abil_req : 5'h00; // abilities only once linked
    clocks_ready    <= ready_req;
    wake_frame_evt  <= frame_tgl ^ frame_seen;
    frame_seen      <= frame_tgl;
    remote_wake_evt <= remote_tgl ^ remote_seen;
    remote_seen     <= remote_tgl;
  end
endmodule : pwr_line_model

// ---- pwr_pkg.sv ----
package pwr_pkg;

  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_ENERGY = 2'b01,
    PM_RSVD   = 2'b10,
    PM_SAVING = 2'b11
  } pwr_mode_t;

  typedef enum logic {
    PS_NORMAL = 1'b0,
    PS_LOW    = 1'b1
  } pwr_pstate_t;

  typedef struct packed {
    logic        pme_dly;
    logic        pme_pol;
    logic [3:0]  wake_en;
    logic        auto_wake;
    logic        wake_to_normal;
    logic [3:0]  wake_evt;
    pwr_mode_t   pm_mode;
    logic [7:0]  wake_time;
    logic [7:0]  sleep_time;
    logic        phy_rst;
    logic        loopback;
    logic        force_100;
    logic        an_en;
    logic        an_restart;
    logic        force_full;
    logic        xover_var;
    logic        force_mdi;
    logic        xover_dis;
    logic        tx_dis;
    logic        led_off;
    logic [4:0]  adv;
    pwr_pstate_t pstate;
    logic [31:0] ms_cnt;
    logic [31:0] wake_cnt;
    logic [31:0] sleep_cnt;
    logic        energy_s1;
    logic        energy_s2;
    logic        link_prev;
    logic [15:0] rdata;
    logic        wake_out;
    logic        isr_energy;
    logic        isr_link;
  } pwr_state_t;

endpackage : pwr_pkg

// ---- pwr_regs.sv ----
// Contract
// - wake output active high when polarity bit 12 is 1, else low
// - enable bits 11-8 gate frame, remote packet, link-up, energy events
// - auto wake-up bit 7: low to normal power after energy lasts wake time
// - bit 6 with bit 7 returns power mode field to normal on wake
// - wake event field 5-2 one-hot: frame, remote, link up, energy
// - energy wake sets interrupt bit 2; link-up wake sets bit 3
// - wake output asserts for enabled recorded event, drops when cleared
// - event bits clear only at power-up reset or host write of one
// - mode field 1-0: normal, energy detect, power saving; 10 reserved
// - wake needs continuous energy for wake time, 16 ms units, default 8
// - low power entered after no energy for go-sleep time, 1 s units
// - writing one to PHY reset bit pulses reset, bit self-clears
// - basic control bit 14 loops host transmit back to host receive
// - without autoneg bit 13 forces speed; bit 8 forces duplex
// - bit 9 restarts autoneg; control bits shared with port control
// - bit 3 disables crossover, bit 4 forces MDI, bit 5 picks variant
// - bit 1 disables transmitter, bit 0 turns off port LEDs
// - basic status bit 2 link up, bit 5 autoneg complete, mirrored
// - advertisement bits 10,8,7,6,5 writable; selector reads 0x01
// - partner ability bits 10,8,7,6,5 read-only from received abilities
// - fixed PHY identifier split into low and high read-only registers
// - delay bit 14 with auto wake holds wake output until clocks ready
`timescale 1ns/100ps
`include "pwr_defines.svh"

module pwr_regs
  import pwr_pkg::*;
#(
  parameter int unsigned    CYC_PER_MS    = `PWR_CYC_PER_MS,
  parameter int unsigned    WAKE_UNIT_MS  = `PWR_WAKE_UNIT_MS,
  parameter int unsigned    SLEEP_UNIT_MS = `PWR_SLEEP_UNIT_MS,
  parameter logic [15:0]    PHY_ID_LOW    = 16'h5A3C, // arbitrary value
  parameter logic [15:0]    PHY_ID_HIGH   = 16'h00A5  // arbitrary value
) (
  // clock and power-up reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // host register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [1:0]   reg_be,
  input  wire logic [15:0]  reg_wdata,
  output logic [15:0]       reg_rdata,
  // events and status from the PHY and MAC
  input  wire logic         energy_detect,
  input  wire logic         link_up,
  input  wire logic         an_done,
  input  wire logic         op_speed_100,
  input  wire logic         op_full_duplex,
  input  wire logic         mdi_status,
  input  wire logic [4:0]   partner_abil,
  input  wire logic         wake_frame_evt,
  input  wire logic         remote_wake_evt,
  input  wire logic         clocks_ready,
  // wake pin and interrupt status sets
  output logic              wake_event_out,
  output logic              isr_energy_set,
  output logic              isr_link_set,
  // power control
  output logic [1:0]        power_mode,
  output logic              low_power_state,
  output logic              phy_reset_out,
  // PHY control
  output logic              host_side_loopback,
  output logic              force_100,
  output logic              an_enable,
  output logic              an_restart,
  output logic              force_full,
  output logic              crossover_variant_sel,
  output logic              force_mdi,
  output logic              auto_xover_dis,
  output logic              tx_disable,
  output logic              led_off,
  output logic [4:0]        adv_abilities
);

  // refuse timing parameters the counters cannot serve
  if (CYC_PER_MS < 1 || WAKE_UNIT_MS < 1 || SLEEP_UNIT_MS < 1) begin : g_bad_unit
    $error("pwr_regs: timing parameters must be at least one");
  end
  if (SLEEP_UNIT_MS > 16000000 || WAKE_UNIT_MS > 16000000) begin : g_bad_span
    $error("pwr_regs: time unit overflows the counter");
  end

  localparam pwr_state_t RST = '{
    wake_time:  `PWR_RST_WAKE_TIME,
    sleep_time: `PWR_RST_SLEEP_TIME,
    force_100:  1'b1,
    an_en:      1'b1,
    force_full: 1'b1,
    xover_var:  1'b1,
    adv:        `PWR_RST_ADV,
    wake_out:   1'b1,
    pm_mode:    PM_NORMAL,
    pstate:     PS_NORMAL,
    default:    '0
  };

  pwr_state_t s;
  pwr_state_t n;

  // byte-lane merge of a write into a register image
  function automatic logic [15:0] pwr_merge(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be);
    pwr_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : pwr_merge

  logic [15:0] img_pmec;
  logic [15:0] img_timing;
  logic [15:0] img_bctrl;
  logic [15:0] img_bstat;
  logic [15:0] img_adv;
  logic [15:0] img_lpa;
  logic [15:0] img_pctrl;
  logic [15:0] img_pstat;
  logic [15:0] wm;
  logic        tick;
  logic        ev_energy;
  logic        ev_link;
  logic [3:0]  ev_set;
  logic [3:0]  ev_clr;
  logic        wake_hold;
  logic [31:0] wake_tgt;
  logic [31:0] sleep_tgt;

  // register read images; aliased bits come from one storage flop
  always_comb begin
    img_pmec   = {1'b0, s.pme_dly, 1'b0, s.pme_pol, s.wake_en, s.auto_wake,
                  s.wake_to_normal, s.wake_evt, s.pm_mode};
    img_timing = {s.wake_time, s.sleep_time};
    img_bctrl  = {1'b0, s.loopback, s.force_100, s.an_en, 2'b00, s.an_restart,
                  s.force_full, 2'b00, s.xover_var, s.force_mdi, s.xover_dis,
                  1'b0, s.tx_dis, s.led_off};
    img_bstat  = `PWR_BSTAT_FIXED | {10'h000, an_done, 2'b00, link_up, 2'b00};
    img_adv    = {5'h00, s.adv[4], 1'b0, s.adv[3:0], `PWR_ADV_SELECTOR};
    img_lpa    = {5'h00, partner_abil[4], 1'b0, partner_abil[3:0], `PWR_ADV_SELECTOR};
    img_pctrl  = {s.led_off, s.tx_dis, s.an_restart, 2'b00, s.xover_dis, s.force_mdi,
                  1'b0, s.an_en, s.force_100, s.force_full, s.adv};
    img_pstat  = {s.xover_var, 4'h0, op_speed_100, op_full_duplex, 1'b0, mdi_status,
                  an_done, link_up, partner_abil};
  end

  // timer targets in milliseconds
  always_comb begin
    wake_tgt  = 32'(s.wake_time * WAKE_UNIT_MS);
    sleep_tgt = 32'(s.sleep_time * SLEEP_UNIT_MS);
    tick      = (s.ms_cnt == 32'(CYC_PER_MS - 1));
    // hold off while clocks not ready
    wake_hold = s.pme_dly && s.auto_wake && !clocks_ready;
  end

  // next-state logic
  always_comb begin
    n            = s;
    ev_energy    = 1'b0;
    ev_link      = 1'b0;
    ev_clr       = 4'h0;
    wm           = 16'h0000;
    n.energy_s1  = energy_detect;
    n.energy_s2  = s.energy_s1;
    n.link_prev  = link_up;
    n.phy_rst    = 1'b0;
    n.isr_energy = 1'b0;
    n.isr_link   = 1'b0;
    n.ms_cnt     = tick ? 32'h00000000 : s.ms_cnt + 32'h00000001;

    // register reads, answered one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        `PWR_OFS_PMEC:   n.rdata = img_pmec;
        `PWR_OFS_TIMING: n.rdata = img_timing;
        `PWR_OFS_PHYRST: n.rdata = 16'h0000;
        `PWR_OFS_BCTRL:  n.rdata = img_bctrl;
        `PWR_OFS_BSTAT:  n.rdata = img_bstat;
        `PWR_OFS_IDLO:   n.rdata = PHY_ID_LOW;
        `PWR_OFS_IDHI:   n.rdata = PHY_ID_HIGH;
        `PWR_OFS_ADV:    n.rdata = img_adv;
        `PWR_OFS_LPA:    n.rdata = img_lpa;
        `PWR_OFS_PCTRL:  n.rdata = img_pctrl;
        `PWR_OFS_PSTAT:  n.rdata = img_pstat;
        default:         n.rdata = 16'h0000;
      endcase
    end

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `PWR_OFS_PMEC: begin
          wm               = pwr_merge(img_pmec, reg_wdata, reg_be);
          n.pme_dly        = wm[`PWR_PMEC_DLY];
          n.pme_pol        = wm[`PWR_PMEC_POL];
          n.wake_en        = wm[`PWR_PMEC_EN_HI:`PWR_PMEC_EN_LO];
          n.auto_wake      = wm[`PWR_PMEC_AUTO];
          n.wake_to_normal = wm[`PWR_PMEC_W2N];
          // write one to clear, only on written lane
          ev_clr = reg_be[0] ? reg_wdata[`PWR_PMEC_EVT_HI:`PWR_PMEC_EVT_LO] : 4'h0;
          if (pwr_mode_t'(wm[1:0]) != PM_RSVD)
            n.pm_mode = pwr_mode_t'(wm[1:0]);
        end
        `PWR_OFS_TIMING: begin
          wm           = pwr_merge(img_timing, reg_wdata, reg_be);
          n.wake_time  = wm[15:8];
          n.sleep_time = wm[7:0];
        end
        `PWR_OFS_PHYRST: begin
          n.phy_rst = reg_be[0] && reg_wdata[0];
        end
        `PWR_OFS_BCTRL: begin
          wm = pwr_merge(img_bctrl, reg_wdata, reg_be);
          n.loopback   = wm[14];
          n.force_100  = wm[13];
          n.an_en      = wm[12];
          n.force_full = wm[8];
          n.an_restart = wm[9];
          n.xover_var  = wm[5];
          n.force_mdi  = wm[4];
          n.xover_dis  = wm[3];
          n.tx_dis     = wm[1];
          n.led_off    = wm[0];
        end
        `PWR_OFS_ADV: begin
          wm    = pwr_merge(img_adv, reg_wdata, reg_be);
          n.adv = {wm[10], wm[8:5]};
        end
        `PWR_OFS_PCTRL: begin
          // alias writes land in the same flops
          wm           = pwr_merge(img_pctrl, reg_wdata, reg_be);
          n.led_off    = wm[15];
          n.tx_dis     = wm[14];
          n.an_restart = wm[13];
          n.xover_dis  = wm[10];
          n.force_mdi  = wm[9];
          n.an_en      = wm[7];
          n.force_100  = wm[6];
          n.force_full = wm[5];
          n.adv        = wm[4:0];
        end
        `PWR_OFS_PSTAT: begin
          wm          = pwr_merge(img_pstat, reg_wdata, reg_be);
          n.xover_var = wm[15];
        end
        default: ;
      endcase
    end

    // energy detect power state machine
    if (s.pm_mode != PM_ENERGY) begin
      n.pstate    = PS_NORMAL;
      n.wake_cnt  = 32'h00000000;
      n.sleep_cnt = 32'h00000000;
    end else begin
      unique case (s.pstate)
        PS_NORMAL: begin
          n.wake_cnt = 32'h00000000;
          if (s.energy_s2) begin
            n.sleep_cnt = 32'h00000000;
          end else if (tick) begin
            if (s.sleep_cnt + 32'h00000001 >= sleep_tgt) begin
              n.pstate    = PS_LOW;
              n.sleep_cnt = 32'h00000000;
            end else begin
              n.sleep_cnt = s.sleep_cnt + 32'h00000001;
            end
          end
        end
        PS_LOW: begin
          n.sleep_cnt = 32'h00000000;
          if (!s.energy_s2) begin
            n.wake_cnt = 32'h00000000;
          end else if (tick && s.wake_cnt < wake_tgt) begin
            n.wake_cnt = s.wake_cnt + 32'h00000001;
            if (s.wake_cnt + 32'h00000001 == wake_tgt) begin
              ev_energy = 1'b1;
              if (s.auto_wake) begin
                n.pstate   = PS_NORMAL;
                n.wake_cnt = 32'h00000000;
                if (s.wake_to_normal)
                  n.pm_mode = PM_NORMAL;
              end
            end
          end
        end
      endcase
    end

    // one-hot event recording, set wins over clear
    ev_link    = link_up && !s.link_prev;
    ev_set     = {wake_frame_evt, remote_wake_evt, ev_link, ev_energy};
    n.wake_evt = (s.wake_evt & ~ev_clr) | ev_set;
    n.isr_energy = ev_energy;
    n.isr_link   = ev_link;

    if ((|(s.wake_evt & s.wake_en)) && !wake_hold)
      n.wake_out = s.pme_pol;
    else
      n.wake_out = ~s.pme_pol;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      s <= RST;
    else
      s <= n;
  end

  // outputs straight from flops
  assign reg_rdata             = s.rdata;
  assign wake_event_out        = s.wake_out;
  assign isr_energy_set        = s.isr_energy;
  assign isr_link_set          = s.isr_link;
  assign power_mode            = s.pm_mode;
  assign low_power_state       = s.pstate;
  assign phy_reset_out         = s.phy_rst;
  assign host_side_loopback    = s.loopback;
  assign force_100             = s.force_100;
  assign an_enable             = s.an_en;
  assign an_restart            = s.an_restart;
  assign force_full            = s.force_full;
  assign crossover_variant_sel = s.xover_var;
  assign force_mdi             = s.force_mdi;
  assign auto_xover_dis        = s.xover_dis;
  assign tx_disable            = s.tx_dis;
  assign led_off               = s.led_off;
  assign adv_abilities         = s.adv;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wake_active_lvl: assert property (
    ((|(s.wake_evt & s.wake_en)) && !wake_hold) |=> wake_event_out == $past(s.pme_pol))
    else $error("wake pin not at active level");
  a_wake_gated_off: assert property (
    (s.wake_en == 4'h0) |=> wake_event_out == !$past(s.pme_pol))
    else $error("wake pin asserted with all enables off");
  a_no_auto_stay: assert property (
    (s.pstate == PS_LOW && !s.auto_wake && s.pm_mode == PM_ENERGY)
      |=> (s.pstate == PS_LOW || $past(s.pm_mode) != PM_ENERGY))
    else $error("left low power without auto wake");
  a_mode_to_normal: assert property (
    (ev_energy && s.auto_wake && s.wake_to_normal) |=> s.pm_mode == PM_NORMAL)
    else $error("mode not returned to normal");
  a_energy_isr: assert property (
    $rose(s.wake_evt[0]) |-> isr_energy_set)
    else $error("energy event without interrupt set");
  a_event_sticky: assert property (
    (!reg_wr) |=> ((s.wake_evt & $past(s.wake_evt)) == $past(s.wake_evt)))
    else $error("event bit cleared without host write");
  a_low_needs_ed: assert property (
    (s.pm_mode != PM_ENERGY) |=> s.pstate == PS_NORMAL)
    else $error("low power outside energy detect mode");
  a_phy_rst_pulse: assert property (
    (phy_reset_out && !reg_wr) |=> !phy_reset_out)
    else $error("PHY reset longer than one cycle");
  a_delay_hold: assert property (
    wake_hold |=> wake_event_out == !$past(s.pme_pol))
    else $error("wake pin asserted before clocks ready");

  c_energy_wake: cover property (ev_energy && s.auto_wake);
  c_enter_low:   cover property ($rose(low_power_state));
  c_link_wake:   cover property (ev_link && s.wake_en[1]);
  c_phy_reset:   cover property (phy_reset_out);

endmodule : pwr_regs

// ---- test_power_wake_and_phy_mii_regs.sv ----
`timescale 1ns/100ps
`include "pwr_defines.svh"

module test_power_wake_and_phy_mii_regs
  import pwr_pkg::*;
;
  localparam logic [15:0] ID_LO = 16'hC3A1; // arbitrary value
  localparam logic [15:0] ID_HI = 16'h5E07; // arbitrary value
  localparam int          LIMIT = 6000;
  logic        clk, rst_n, reg_wr, reg_rd, wake_event_out, isr_energy_set, isr_link_set;
  logic [7:0]  reg_addr;
  logic [1:0]  reg_be, power_mode;
  logic [15:0] reg_wdata, reg_rdata;
  logic        energy_detect, link_up, an_done, op_speed_100, op_full_duplex, mdi_status;
  logic [4:0]  partner_abil, adv_abilities, abil_req;
  logic        wake_frame_evt, remote_wake_evt, clocks_ready, low_power_state, phy_reset_out;
  logic        host_side_loopback, force_100, an_enable, an_restart, force_full;
  logic        crossover_variant_sel, force_mdi, auto_xover_dis, tx_disable, led_off;
  logic        energy_req, link_req, frame_tgl, remote_tgl, ready_req;
  int          failures = 0, n_compared = 0, n_cyc = 0, n_ie = 0, n_il = 0, n_rst = 0;

  pwr_regs #(.CYC_PER_MS(10), .WAKE_UNIT_MS(2), .SLEEP_UNIT_MS(3),
             .PHY_ID_LOW(ID_LO), .PHY_ID_HIGH(ID_HI)) u_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .energy_detect(energy_detect), .link_up(link_up), .an_done(an_done),
    .op_speed_100(op_speed_100), .op_full_duplex(op_full_duplex), .mdi_status(mdi_status),
    .partner_abil(partner_abil), .wake_frame_evt(wake_frame_evt),
    .remote_wake_evt(remote_wake_evt), .clocks_ready(clocks_ready),
    .wake_event_out(wake_event_out), .isr_energy_set(isr_energy_set),
    .isr_link_set(isr_link_set), .power_mode(power_mode), .low_power_state(low_power_state),
    .phy_reset_out(phy_reset_out), .host_side_loopback(host_side_loopback),
    .force_100(force_100), .an_enable(an_enable), .an_restart(an_restart),
    .force_full(force_full), .crossover_variant_sel(crossover_variant_sel),
    .force_mdi(force_mdi), .auto_xover_dis(auto_xover_dis), .tx_disable(tx_disable),
    .led_off(led_off), .adv_abilities(adv_abilities));

  pwr_line_model u_line (
    .clk(clk), .energy_req(energy_req), .link_req(link_req), .abil_req(abil_req),
    .frame_tgl(frame_tgl), .remote_tgl(remote_tgl), .ready_req(ready_req),
    .energy_detect(energy_detect), .link_up(link_up), .an_done(an_done),
    .op_speed_100(op_speed_100), .op_full_duplex(op_full_duplex), .mdi_status(mdi_status),
    .partner_abil(partner_abil), .wake_frame_evt(wake_frame_evt),
    .remote_wake_evt(remote_wake_evt), .clocks_ready(clocks_ready));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pulse counters and hang guard, sampled between edges
  always @(negedge clk) begin
    n_cyc++;
    if (isr_energy_set === 1'b1) n_ie++;
    if (isr_link_set === 1'b1) n_il++;
    if (phy_reset_out === 1'b1) n_rst++;
    if (n_cyc == LIMIT) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one write strobe, then a quiet cycle
  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk(reg_rdata & m, e & m);
  endtask : rd_chk

  task automatic wait_out(input logic lvl);
    for (int i = 0; i < 8 && wake_event_out !== lvl; i++) @(negedge clk);
    chk({15'h0, wake_event_out}, {15'h0, lvl});
  endtask : wait_out

  task automatic fire(input int k);
    if (k == 1) link_req <= 1'b1;
    if (k == 2) remote_tgl <= ~remote_tgl;
    if (k == 3) frame_tgl <= ~frame_tgl;
    @(negedge clk);
  endtask : fire

  task automatic t_reset();
    chk({15'h0, wake_event_out}, 16'h0001);
    rd_chk(`PWR_OFS_PMEC, 16'h0000, 16'hFFFF);
    rd_chk(`PWR_OFS_TIMING, 16'h080C, 16'hFFFF);
    rd_chk(`PWR_OFS_BCTRL, 16'h3120, 16'hFFFF);
    rd_chk(`PWR_OFS_BSTAT, 16'h3050, 16'hFFFF);
    rd_chk(`PWR_OFS_IDLO, ID_LO, 16'hFFFF);
    rd_chk(`PWR_OFS_IDHI, ID_HI, 16'hFFFF);
    rd_chk(`PWR_OFS_ADV, 16'h05E1, 16'hFFFF);
    rd_chk(`PWR_OFS_PCTRL, 16'h00FF, 16'hFFFF);
    rd_chk(`PWR_OFS_PSTAT, 16'h8080, 16'hFFFF);
    rd_chk(8'hDA, 16'h0000, 16'hFFFF);
    $display("reset values test ended");
  endtask : t_reset

  task automatic t_alias();
    wr(`PWR_OFS_BCTRL, 2'b11, 16'h421B);
    chk({6'h0, host_side_loopback, force_100, an_enable, an_restart, force_full,
         crossover_variant_sel, force_mdi, auto_xover_dis, tx_disable, led_off},
        16'h024F);
    rd_chk(`PWR_OFS_BCTRL, 16'h421B, 16'hFFFF);
    rd_chk(`PWR_OFS_PCTRL, 16'hE61F, 16'hFFFF);
    wr(`PWR_OFS_PCTRL, 2'b11, 16'h00E0);
    rd_chk(`PWR_OFS_BCTRL, 16'h7100, 16'hFFFF);
    rd_chk(`PWR_OFS_ADV, 16'h0001, 16'hFFFF);
    wr(`PWR_OFS_ADV, 2'b11, 16'hFFFF);
    rd_chk(`PWR_OFS_ADV, 16'h05E1, 16'hFFFF);
    chk({11'h0, adv_abilities}, 16'h001F);
    // crossover variant written through the port status alias
    wr(`PWR_OFS_PSTAT, 2'b10, 16'h8000);
    rd_chk(`PWR_OFS_BCTRL, 16'h0020, 16'h0020);
    $display("alias test ended");
  endtask : t_alias

  task automatic t_events();
    int n0;
    wr(`PWR_OFS_PMEC, 2'b11, 16'h1F00);
    for (int k = 1; k < 4; k++) begin
      n0 = n_il;
      fire(k);
      wait_out(1'b1);
      rd_chk(`PWR_OFS_PMEC, 16'h0004 << k, 16'h003C);
      chk(16'(n_il - n0), {15'h0, k == 1});
      wr(`PWR_OFS_PMEC, 2'b01, 16'h003C);
      wait_out(1'b0);
    end
    wr(`PWR_OFS_PMEC, 2'b11, 16'h1700);
    fire(3);
    repeat (4) @(negedge clk);
    chk({15'h0, wake_event_out}, 16'h0000);
    wr(`PWR_OFS_PMEC, 2'b10, 16'h0800);
    wait_out(1'b0);
    wr(`PWR_OFS_PMEC, 2'b01, 16'h003C);
    wait_out(1'b1);
    $display("wake events test ended");
  endtask : t_events

  task automatic t_status();
    abil_req <= 5'h1F;
    repeat (3) @(negedge clk);
    rd_chk(`PWR_OFS_BSTAT, 16'h3074, 16'hFFFF);
    rd_chk(`PWR_OFS_PSTAT, 16'h86FF, 16'hFFFF);
    rd_chk(`PWR_OFS_LPA, 16'h05C0, 16'h05C0);
    wr(`PWR_OFS_LPA, 2'b11, 16'h0000);
    rd_chk(`PWR_OFS_LPA, 16'h05C0, 16'h05C0);
    abil_req <= 5'h0A;
    repeat (3) @(negedge clk);
    rd_chk(`PWR_OFS_LPA, 16'h0140, 16'h05C0);
    $display("status test ended");
  endtask : t_status

  task automatic t_modes();
    logic [1:0] cd [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
    logic [1:0] ex [4] = '{2'b11, 2'b11, 2'b01, 2'b00};
    int n0;
    for (int i = 0; i < 4; i++) begin
      wr(`PWR_OFS_PMEC, 2'b01, {14'h0, cd[i]});
      chk({14'h0, power_mode}, {14'h0, ex[i]});
      rd_chk(`PWR_OFS_PMEC, {14'h0, ex[i]}, 16'h0003);
    end
    fire(3);
    n0 = n_rst;
    wr(`PWR_OFS_PHYRST, 2'b01, 16'h0001);
    chk(16'(n_rst - n0), 16'h0001);
    rd_chk(`PWR_OFS_PHYRST, 16'h0000, 16'hFFFF);
    rd_chk(`PWR_OFS_PMEC, 16'h0020, 16'h003C);
    wr(`PWR_OFS_PMEC, 2'b10, 16'h003C);
    rd_chk(`PWR_OFS_PMEC, 16'h0020, 16'h003C);
    wr(`PWR_OFS_PMEC, 2'b01, 16'h003C);
    rd_chk(`PWR_OFS_PMEC, 16'h0000, 16'h003C);
    $display("mode and reset test ended");
  endtask : t_modes

  task automatic t_energy();
    int n0;
    // host keeps both time fields nonzero
    wr(`PWR_OFS_TIMING, 2'b11, 16'h0202);
    wr(`PWR_OFS_PMEC, 2'b11, 16'h51C1);
    ready_req <= 1'b0;
    energy_req <= 1'b0;
    repeat (45) @(negedge clk);
    chk({15'h0, low_power_state}, 16'h0000);
    for (int i = 0; i < 40 && low_power_state !== 1'b1; i++) @(negedge clk);
    chk({15'h0, low_power_state}, 16'h0001);
    n0 = n_ie;
    energy_req <= 1'b1;
    repeat (25) @(negedge clk);
    chk({15'h0, low_power_state}, 16'h0001);
    for (int i = 0; i < 40 && low_power_state !== 1'b0; i++) @(negedge clk);
    chk({15'h0, low_power_state}, 16'h0000);
    chk({14'h0, power_mode}, {14'h0, PM_NORMAL});
    // whole register: mode back to normal, energy event recorded
    rd_chk(`PWR_OFS_PMEC, 16'h51C4, 16'hFFFF);
    // pulse counted on the same falling edge that first sees the wake, so looked at only now
    chk(16'(n_ie - n0), 16'h0001);
    chk({15'h0, wake_event_out}, 16'h0000);
    ready_req <= 1'b1;
    wait_out(1'b1);
    wr(`PWR_OFS_PMEC, 2'b01, 16'h003C);
    wait_out(1'b0);
    $display("energy detect test ended");
  endtask : t_energy

  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_be = 2'b00;
    reg_wdata = 16'h0000;
    energy_req = 1'b1;
    link_req = 1'b0;
    abil_req = 5'h00;
    frame_tgl = 1'b0;
    remote_tgl = 1'b0;
    ready_req = 1'b1;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_alias();
    t_events();
    t_status();
    t_modes();
    t_energy();
    close_out();
  end
endmodule : test_power_wake_and_phy_mii_regs
